// ---- common/dtim_pkg.sv ----
// constants, field layouts and helpers shared by the dual timer block
// ****************************************************************
// Contract
// - timer A count is 8-bit, read/write, steps once per tick, resets to zero.
// - timer A wrap from FFH to 00H keeps counting and raises its request.
// - timer A mode bit 7 runs the timer when 1, stops it when 0.
// - timer A rate bits 6..4 pick cpu clock /256 for 000 down to /2.
// - timer A mode bit 0 picks prescaled cpu clock or real-time mode.
// - real-time mode ignores rate and count, timing out every 0.5 s.
// - timer B is an 8-bit up counter wrapping FF to 00 with request.
// - timer B mode bit 7 runs timer B when 1, stops it when 0.
// - timer B rate picks cpu /256../2 or oscillator /128../1 by fast flag.
// - timer B fast-clock flag is bit 2 of timer A mode, resets to 0.
// - timer B mode bit 3 picks internal clock or falling pin edges.
// - in event mode rate is unused and the pin raises no request.
// - timer B mode bit 0 enables pwm, cycle length set by toggle and reload bits.
// - without pwm, bit 1 drives a per-timeout toggle onto the output pin.
// - without pwm, bit 2 enables auto-reload of the counter on wrap.
// - in pwm mode the wrap boundary follows the chosen pwm cycle.
// - pwm boundaries are 256, 64, 32, 16 counts; reload forced on.
// - wrap with reload loads the reload value; new values apply next wrap.
// ****************************************************************
package dtim_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE_A = 8'hd8;
  localparam logic [7:0] ADDR_COUNT_A = 8'hd9;
  localparam logic [7:0] ADDR_MODE_B = 8'hda;
  localparam logic [7:0] ADDR_COUNT_B = 8'hdb;
  localparam logic [7:0] ADDR_RELOAD_B = 8'hcd;
  localparam logic [7:0] ADDR_FLAGS = 8'hc0;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hc1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MODE_A_WMASK = 8'hf5;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] BOUND_64 = 8'h3f;
  localparam logic [7:0] BOUND_32 = 8'h1f;
  localparam logic [7:0] BOUND_16 = 8'h0f;
  localparam logic [2:0] EXT_SYNC_RST = 3'h7;
  // flag and enable bit positions
  localparam int NUM_FLAGS = 3;
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_EXT = 2;
  // prescaler depth in powers of two for rate code 000
  localparam int CPU_DIV_LOG = 8;
  localparam int OSC_DIV_LOG = 7;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int RTC_PERIOD_NS = 500000000;
  localparam int RTC_CYCLES = RTC_PERIOD_NS / CLK_PERIOD_NS;
  // ****************************************************************
  // mode register layouts
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic [2:0] rate;
    logic rsvd3;
    logic fastClk;
    logic rsvd1;
    logic rtcSel;
  } dtim_mode_a_t;
  typedef struct packed {
    logic enable;
    logic [2:0] rate;
    logic srcSel;
    logic autoReload;
    logic toggleOut;
    logic pwmEnable;
  } dtim_mode_b_t;
  // wrap mask of timer B for its current mode
  function automatic logic [7:0] boundMask(input dtim_mode_b_t m);
    logic [7:0] r;
    r = COUNT_MAX;
    if (m.pwmEnable) begin
      unique case ({m.autoReload, m.toggleOut})
        2'b00: r = COUNT_MAX;
        2'b01: r = BOUND_64;
        2'b10: r = BOUND_32;
        2'b11: r = BOUND_16;
      endcase
    end
    return r;
  endfunction
endpackage

// ---- rtl/dtim_prescaler.sv ----
// power-of-two prescaler giving one tick per selected number of source ticks
`timescale 1ns/1ps
module dtim_prescaler
  import dtim_pkg::*;
#(
  parameter int BASE_LOG = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // source and selection
  input wire logic srcTick,
  input wire logic [2:0] sel,
  // divided tick, combinational
  output logic tick
);
  localparam logic [4:0] BASE = 5'(BASE_LOG);
  logic [BASE_LOG-1:0] divCnt_q;
  logic [BASE_LOG-1:0] mask;

  // rate code 111 must still leave a shift of zero or more
  if (BASE_LOG < 7 || BASE_LOG > 16) begin : g_bad_base
    $error("prescaler depth out of range");
  end

  // free-running divider, advances only on source ticks
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      divCnt_q <= '0;
    end else if (srcTick) begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

  // code 000 divides by 2**BASE, each step halves it
  assign mask = ~({BASE_LOG{1'b1}} << (BASE - {2'b00, sel}));
  assign tick = srcTick && ((divCnt_q & mask) == mask);
endmodule

// ---- rtl/dtim_top.sv ----
// two 8-bit timers with register port, event input and toggle/pwm pin
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module dtim_top
  import dtim_pkg::*;
#(
  parameter int RTC_TICKS = RTC_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // counting sources, one-cycle pulses
  input wire logic cpuTick,
  input wire logic oscTick,
  // external event and interrupt pin
  input wire logic extIrqPin,
  // interrupt requests
  output logic timerAIrq,
  output logic timerBIrq,
  output logic extIrq,
  // toggle or pwm output pin
  output logic togglePinOut,
  output logic togglePinOe
);
  localparam int RTC_W = $clog2(RTC_TICKS);
  localparam logic [RTC_W-1:0] RTC_LAST = RTC_W'(RTC_TICKS - 1);

  // a one-cycle real-time period would leave no room to count
  if (RTC_TICKS < 2) begin : g_bad_rtc
    $error("real-time period too short");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  dtim_mode_a_t modeA_q;
  dtim_mode_b_t modeB_q;
  logic [7:0] countA_q;
  logic [7:0] countB_q;
  logic [7:0] reloadBuf_q;
  logic [7:0] reloadAct_q;
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] irqEn_q;
  logic [NUM_FLAGS-1:0] irqOut_q;
  logic [RTC_W-1:0] rtcCnt_q;
  logic [2:0] extSync_q;
  logic toggle_q;
  logic pinOut_q;
  logic pinOe_q;
  logic [7:0] rdData_q;
  logic [7:0] rdMux;

  // ****************************************************************
  // decode and tick selection
  // ****************************************************************
  // strobe and address are arguments so every caller sees them change
  function automatic logic wrHit(input logic wr, input logic [7:0] addr,
                                 input logic [7:0] a);
    return wr && (addr == a);
  endfunction

  logic wrModeA;
  logic wrCountA;
  logic wrModeB;
  logic wrCountB;
  logic wrReload;
  logic wrFlags;
  logic wrIrqEn;
  logic preTickA;
  logic preTickBCpu;
  logic preTickBOsc;
  logic rtcTick;
  logic stepA;
  logic ovfA;
  logic extFall;
  logic tickB;
  logic ovfB;
  logic reloadOn;
  logic [7:0] bMask;
  logic [NUM_FLAGS-1:0] flagSet;

  assign wrModeA = wrHit(regWr, regAddr, ADDR_MODE_A);
  assign wrCountA = wrHit(regWr, regAddr, ADDR_COUNT_A);
  assign wrModeB = wrHit(regWr, regAddr, ADDR_MODE_B);
  assign wrCountB = wrHit(regWr, regAddr, ADDR_COUNT_B);
  assign wrReload = wrHit(regWr, regAddr, ADDR_RELOAD_B);
  assign wrFlags = wrHit(regWr, regAddr, ADDR_FLAGS);
  assign wrIrqEn = wrHit(regWr, regAddr, ADDR_IRQ_EN);

  // timer A cpu prescaler
  dtim_prescaler #(
    .BASE_LOG(CPU_DIV_LOG)
  ) u_pre_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .srcTick(cpuTick),
    .sel(modeA_q.rate),
    .tick(preTickA)
  );

  // timer B cpu prescaler
  dtim_prescaler #(
    .BASE_LOG(CPU_DIV_LOG)
  ) u_pre_b_cpu (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .srcTick(cpuTick),
    .sel(modeB_q.rate),
    .tick(preTickBCpu)
  );

  // timer B oscillator prescaler, one octave shallower
  dtim_prescaler #(
    .BASE_LOG(OSC_DIV_LOG)
  ) u_pre_b_osc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .srcTick(oscTick),
    .sel(modeB_q.rate),
    .tick(preTickBOsc)
  );

  // timer A: real-time mode drops both rate and count
  assign rtcTick = (rtcCnt_q == RTC_LAST);
  assign stepA = modeA_q.enable && !modeA_q.rtcSel && preTickA;
  assign ovfA = modeA_q.enable && (modeA_q.rtcSel ? rtcTick
    : (preTickA && (countA_q == COUNT_MAX)));

  // edge from the two settled samples only
  assign extFall = extSync_q[2] && !extSync_q[1];

  // timer B source: pin edges or the prescaler picked by the fast flag
  assign tickB = modeB_q.enable && (modeB_q.srcSel ? extFall
    : (modeA_q.fastClk ? preTickBOsc : preTickBCpu));
  assign bMask = boundMask(modeB_q);
  assign ovfB = tickB && ((countB_q & bMask) == bMask);
  assign reloadOn = modeB_q.pwmEnable || modeB_q.autoReload;

  // hardware events feeding the sticky flags
  assign flagSet[FLAG_A] = ovfA;
  assign flagSet[FLAG_B] = ovfB;
  assign flagSet[FLAG_EXT] = extFall && !modeB_q.srcSel;

  // ****************************************************************
  // mode registers
  // ****************************************************************
  // reserved bits of mode A never store, so they read as zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      modeA_q <= dtim_mode_a_t'(RESET_BYTE);
    end else if (wrModeA) begin
      modeA_q <= dtim_mode_a_t'(regWrData & MODE_A_WMASK);
    end
  end

  // timer B mode
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      modeB_q <= dtim_mode_b_t'(RESET_BYTE);
    end else if (wrModeB) begin
      modeB_q <= dtim_mode_b_t'(regWrData);
    end
  end

  // ****************************************************************
  // timer A
  // ****************************************************************
  // software write wins over a step in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      countA_q <= RESET_BYTE;
    end else if (wrCountA) begin
      countA_q <= regWrData;
    end else if (stepA) begin
      countA_q <= countA_q + 1'b1;
    end
  end

  // real-time divider restarts whenever the mode is left
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rtcCnt_q <= '0;
    end else if (!(modeA_q.enable && modeA_q.rtcSel)) begin
      rtcCnt_q <= '0;
    end else if (rtcTick) begin
      rtcCnt_q <= '0;
    end else begin
      rtcCnt_q <= rtcCnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // timer B
  // ****************************************************************
  // pin synchroniser; reset high so release makes no false edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      extSync_q <= EXT_SYNC_RST;
    end else begin
      extSync_q <= {extSync_q[1:0], extIrqPin};
    end
  end

  // count: write, then wrap or reload, then step
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      countB_q <= RESET_BYTE;
    end else if (wrCountB) begin
      countB_q <= regWrData;
    end else if (ovfB && reloadOn) begin
      countB_q <= reloadBuf_q;
    end else if (tickB) begin
      countB_q <= countB_q + 1'b1;
    end
  end

  // reload: first buffer takes writes, live copy moves at wrap only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reloadBuf_q <= RESET_BYTE;
      reloadAct_q <= RESET_BYTE;
    end else begin
      if (wrReload) begin
        reloadBuf_q <= regWrData;
      end
      if (ovfB) begin
        reloadAct_q <= reloadBuf_q;
      end
    end
  end

  // toggle flips on each timeout while the toggle pin is selected
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      toggle_q <= 1'b0;
    end else if (ovfB && modeB_q.toggleOut && !modeB_q.pwmEnable) begin
      toggle_q <= !toggle_q;
    end
  end

  // pin: pwm high in the lower half of its cycle, else the toggle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinOut_q <= 1'b0;
      pinOe_q <= 1'b0;
    end else begin
      pinOe_q <= modeB_q.pwmEnable || modeB_q.toggleOut;
      if (modeB_q.pwmEnable) begin
        pinOut_q <= (countB_q & bMask) <= (bMask >> 1);
      end else begin
        pinOut_q <= toggle_q;
      end
    end
  end

  // ****************************************************************
  // request flags and outputs
  // ****************************************************************
  // set beats a write-one clear landing in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~(wrFlags ? regWrData[NUM_FLAGS-1:0] : '0))
        | flagSet;
      if (modeB_q.srcSel) begin
        flags_q[FLAG_EXT] <= 1'b0;
      end
    end
  end

  // request enables
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqEn_q <= '0;
    end else if (wrIrqEn) begin
      irqEn_q <= regWrData[NUM_FLAGS-1:0];
    end
  end

  // each request is its flag gated by its enable, registered
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_irq
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        irqOut_q[i] <= 1'b0;
      end else begin
        irqOut_q[i] <= flags_q[i] && irqEn_q[i];
      end
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  // reload is write-only and unmapped addresses read zero
  always_comb begin
    rdMux = RESET_BYTE;
    unique case (regAddr)
      ADDR_MODE_A: rdMux = modeA_q;
      ADDR_COUNT_A: rdMux = countA_q;
      ADDR_MODE_B: rdMux = modeB_q;
      ADDR_COUNT_B: rdMux = countB_q;
      ADDR_FLAGS: rdMux = 8'(flags_q);
      ADDR_IRQ_EN: rdMux = 8'(irqEn_q);
      default: rdMux = RESET_BYTE;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_q <= RESET_BYTE;
    end else begin
      rdData_q <= regRd ? rdMux : RESET_BYTE;
    end
  end

  assign regRdData = rdData_q;
  assign timerAIrq = irqOut_q[FLAG_A];
  assign timerBIrq = irqOut_q[FLAG_B];
  assign extIrq = irqOut_q[FLAG_EXT];
  assign togglePinOut = pinOut_q;
  assign togglePinOe = pinOe_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_aWrap;
    modeA_q.enable && !modeA_q.rtcSel && preTickA
      && countA_q == COUNT_MAX && !wrCountA;
  endsequence

  sequence s_bWrapPlain;
    ovfB && !reloadOn && !wrCountB;
  endsequence

  chk_a_wrap_flag: assert property (
    s_aWrap |=> countA_q == RESET_BYTE && flags_q[FLAG_A])
    else $error("timer A wrap did not clear and flag");

  chk_a_stop_hold: assert property (
    !modeA_q.enable && !wrCountA |=> $stable(countA_q))
    else $error("stopped timer A moved");

  chk_a_rtc_count: assert property (
    modeA_q.rtcSel && !wrCountA |=> countA_q == $past(countA_q))
    else $error("timer A count moved in real-time mode");

  chk_a_rtc_period: assert property (
    $rose(modeA_q.enable && modeA_q.rtcSel) |-> !rtcTick [*2])
    else $error("real-time timeout too early");

  chk_b_wrap_flag: assert property (
    s_bWrapPlain |=> countB_q == RESET_BYTE && flags_q[FLAG_B])
    else $error("timer B wrap wrong");

  chk_b_stop_hold: assert property (
    !modeB_q.enable && !wrCountB |=> $stable(countB_q))
    else $error("stopped timer B moved");

  chk_b_reload_load: assert property (
    ovfB && reloadOn && !wrCountB |=> countB_q == $past(reloadBuf_q)
      && reloadAct_q == countB_q)
    else $error("reload not applied at wrap");

  chk_b_pwm_bound: assert property (
    ovfB && modeB_q.pwmEnable |-> reloadOn && (&countB_q[3:0])
      && (countB_q[4] || (modeB_q.autoReload && modeB_q.toggleOut))
      && (countB_q[5] || modeB_q.autoReload)
      && ((&countB_q[7:6]) || modeB_q.autoReload || modeB_q.toggleOut))
    else $error("pwm wrap off its boundary");

  chk_ext_no_req: assert property (
    modeB_q.srcSel |=> !flags_q[FLAG_EXT])
    else $error("event mode raised pin request");

  chk_ext_edge_count: assert property (
    modeB_q.enable && modeB_q.srcSel && extSync_q[2] && !extSync_q[1]
      && !wrCountB && !ovfB |=> countB_q == $past(countB_q) + 8'h01)
    else $error("event edge not counted");

  chk_toggle_flip: assert property (
    ovfB && modeB_q.toggleOut && !modeB_q.pwmEnable
      |=> toggle_q != $past(toggle_q) ##1 pinOut_q == $past(toggle_q))
    else $error("toggle pin did not follow timeout");

  chk_flag_set_wins: assert property (
    ovfA && wrFlags && regWrData[FLAG_A] |=> flags_q[FLAG_A])
    else $error("timer A flag lost to clear");
endmodule

// ---- dv/dual_eight_bit_timers_test.sv ----
// self-checking register-level bench for the dual 8-bit timer block
`timescale 1ns/1ps
module dual_eight_bit_timers_test
  import dtim_pkg::*;
();
  // ****************************************************************
  // signals and design
  // ****************************************************************
  logic mclk;
  logic sys_rst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic cpuTick;
  logic oscTick;
  logic extIrqPin;
  logic timerAIrq;
  logic timerBIrq;
  logic extIrq;
  logic togglePinOut;
  logic togglePinOe;
  int errors;
  int checked;
  logic [7:0] v;
  logic [7:0] pwmBound [4];
  // short real-time period keeps the run brief
  dtim_top #(.RTC_TICKS(20)) dut_u (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .cpuTick(cpuTick),
    .oscTick(oscTick),
    .extIrqPin(extIrqPin),
    .timerAIrq(timerAIrq),
    .timerBIrq(timerBIrq),
    .extIrq(extIrq),
    .togglePinOut(togglePinOut),
    .togglePinOe(togglePinOe)
  );
  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkReg(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    logic [7:0] r;
    rd(a, r);
    chk(nm, e, r);
  endtask
  // pulses spaced by a cycle, so each source tick is seen once
  task automatic pulse(input bit osc, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (osc) begin
        oscTick <= 1'b1;
      end else begin
        cpuTick <= 1'b1;
      end
      @(posedge mclk);
      oscTick <= 1'b0;
      cpuTick <= 1'b0;
    end
  endtask
  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // clock and stimulus
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    cpuTick = 1'b0;
    oscTick = 1'b0;
    extIrqPin = 1'b1;
    pwmBound = '{8'hff, 8'h3f, 8'h1f, 8'h0f};
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    chkReg("modeA", ADDR_MODE_A, 8'h00);
    chkReg("countA", ADDR_COUNT_A, 8'h00);
    chkReg("modeB", ADDR_MODE_B, 8'h00);
    chkReg("countB", ADDR_COUNT_B, 8'h00);
    chkReg("unmapped", 8'h55, 8'h00);
    // undefined mode A bits read back as zero
    wr(ADDR_MODE_A, 8'hff);
    chkReg("modeA mask", ADDR_MODE_A, 8'hf5);
    // setup order: stop, mask, clear, rate, count, unmask, run
    wr(ADDR_MODE_A, 8'h00);
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_FLAGS, 8'hff);
    wr(ADDR_MODE_A, 8'h70);
    wr(ADDR_COUNT_A, 8'hfd);
    wr(ADDR_IRQ_EN, 8'h07);
    wr(ADDR_MODE_A, 8'hf0);
    // rate 111: two cpu ticks per step
    pulse(0, 2);
    chkReg("countA /2", ADDR_COUNT_A, 8'hfe);
    pulse(0, 4);
    chkReg("countA wrap", ADDR_COUNT_A, 8'h00);
    chkReg("flags A", ADDR_FLAGS, 8'h01);
    chk("timerAIrq", 8'h01, {7'h00, timerAIrq});
    pulse(0, 2);
    chkReg("countA after wrap", ADDR_COUNT_A, 8'h01);
    wr(ADDR_IRQ_EN, 8'h06);
    rd(ADDR_FLAGS, v);
    chk("timerAIrq masked", 8'h00, {7'h00, timerAIrq});
    wr(ADDR_FLAGS, 8'h01);
    chkReg("flags cleared", ADDR_FLAGS, 8'h00);
    // stopped timer holds, then resumes
    wr(ADDR_MODE_A, 8'h70);
    pulse(0, 8);
    chkReg("countA held", ADDR_COUNT_A, 8'h01);
    wr(ADDR_MODE_A, 8'hf0);
    pulse(0, 2);
    chkReg("countA resumed", ADDR_COUNT_A, 8'h02);
    // rate 000: 256 cpu ticks per step
    wr(ADDR_MODE_A, 8'h80);
    pulse(0, 256);
    chkReg("countA /256", ADDR_COUNT_A, 8'h03);
    // real-time mode ignores rate and count
    wr(ADDR_MODE_A, 8'h00);
    wr(ADDR_COUNT_A, 8'h33);
    wr(ADDR_FLAGS, 8'hff);
    wr(ADDR_MODE_A, 8'hf1);
    chkReg("rtc early", ADDR_FLAGS, 8'h00);
    v = 8'h00;
    for (int i = 0; i < 30 && v[FLAG_A] !== 1'b1; i++) begin
      pulse(0, 1);
      rd(ADDR_FLAGS, v);
    end
    chk("rtc timeout", 8'h01, v);
    if (v[FLAG_A] !== 1'b1) begin
      test_done();
    end
    chkReg("countA rtc", ADDR_COUNT_A, 8'h33);
    wr(ADDR_MODE_A, 8'h00);
    wr(ADDR_FLAGS, 8'hff);
    // a clear landing on the real-time timeout loses to the set
    wr(ADDR_MODE_A, 8'hf1);
    repeat (18) @(posedge mclk);
    wr(ADDR_FLAGS, 8'h01);
    chkReg("flag set wins", ADDR_FLAGS, 8'h01);
    wr(ADDR_MODE_A, 8'h00);
    wr(ADDR_FLAGS, 8'hff);
    // timer B on cpu clock /2, oscillator ignored
    wr(ADDR_COUNT_B, 8'h10);
    wr(ADDR_MODE_B, 8'hf0);
    pulse(1, 3);
    chkReg("countB no osc", ADDR_COUNT_B, 8'h10);
    pulse(0, 2);
    chkReg("countB cpu", ADDR_COUNT_B, 8'h11);
    // fast flag: oscillator /1
    wr(ADDR_MODE_A, 8'h04);
    wr(ADDR_COUNT_B, 8'hfe);
    pulse(1, 2);
    chkReg("countB wrap", ADDR_COUNT_B, 8'h00);
    chkReg("flags B", ADDR_FLAGS, 8'h02);
    chk("timerBIrq", 8'h01, {7'h00, timerBIrq});
    wr(ADDR_FLAGS, 8'hff);
    // toggle output flips at each wrap
    wr(ADDR_MODE_B, 8'hf2);
    @(posedge mclk);
    #1;
    chk("pin oe", 8'h01, {7'h00, togglePinOe});
    chk("pin idle", 8'h00, {7'h00, togglePinOut});
    wr(ADDR_COUNT_B, 8'hff);
    pulse(1, 1);
    @(posedge mclk);
    #1;
    chk("pin toggled", 8'h01, {7'h00, togglePinOut});
    wr(ADDR_MODE_B, 8'hf0);
    @(posedge mclk);
    #1;
    chk("pin released", 8'h00, {7'h00, togglePinOe});
    // auto-reload, new value used at the following wrap
    wr(ADDR_RELOAD_B, 8'h80);
    wr(ADDR_MODE_B, 8'hf4);
    wr(ADDR_COUNT_B, 8'hff);
    pulse(1, 1);
    chkReg("countB reload", ADDR_COUNT_B, 8'h80);
    wr(ADDR_RELOAD_B, 8'h40);
    pulse(1, 1);
    chkReg("countB no early load", ADDR_COUNT_B, 8'h81);
    wr(ADDR_COUNT_B, 8'hff);
    pulse(1, 1);
    chkReg("countB new reload", ADDR_COUNT_B, 8'h40);
    // pwm boundaries for every reload/toggle code
    wr(ADDR_RELOAD_B, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_FLAGS, 8'hff);
      wr(ADDR_MODE_B, 8'hf1 | (8'(i) << 1));
      wr(ADDR_COUNT_B, pwmBound[i]);
      pulse(1, 1);
      chkReg("pwm wrap count", ADDR_COUNT_B, 8'h00);
      chkReg("pwm wrap flag", ADDR_FLAGS, 8'h02);
      chk("pwm pin", 8'h01, {7'h00, togglePinOut});
    end
    // event counting on pin falls, no pin request
    wr(ADDR_MODE_B, 8'h88);
    wr(ADDR_COUNT_B, 8'h00);
    wr(ADDR_FLAGS, 8'hff);
    @(posedge mclk);
    extIrqPin <= 1'b0;
    repeat (4) @(posedge mclk);
    pulse(1, 4);
    chkReg("event count", ADDR_COUNT_B, 8'h01);
    chkReg("event no ext flag", ADDR_FLAGS, 8'h00);
    @(posedge mclk);
    extIrqPin <= 1'b1;
    repeat (4) @(posedge mclk);
    chkReg("event rise", ADDR_COUNT_B, 8'h01);
    // internal source: the pin fall raises its own request
    wr(ADDR_MODE_B, 8'h00);
    extIrqPin <= 1'b0;
    repeat (4) @(posedge mclk);
    chkReg("ext flag", ADDR_FLAGS, 8'h04);
    chk("extIrq", 8'h01, {7'h00, extIrq});
    test_done();
  end
endmodule
